// ### rtl/i2m_pkg.sv
// package: register map, field positions and shared types of the i2c master receive engine
package i2m_pkg;
   // register byte offsets on the apb bus
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_BAUD   = 8'h04;
   localparam logic [7:0] OFF_DATA   = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   // control register fields
   localparam int CTRL_ENABLE  = 0;
   localparam int CTRL_RX_START  = 1;
   localparam int CTRL_ACK_START = 2;
   localparam int CTRL_ACK_DATA  = 3;
   localparam int CTRL_STOPEN  = 4;
   localparam int CTRL_STOPIE  = 5;
   // status register fields, bits 1..4 are write-one-to-clear, bit 0 clears on a buffer read
   localparam int STAT_FULL    = 0;
   localparam int STAT_OV      = 1;
   localparam int STAT_COLLIDE = 2;
   localparam int STAT_PIF     = 3;
   localparam int STAT_BCL     = 4;
   localparam int STAT_STOPDET = 5;
   localparam int STAT_STARTDET = 6;
   localparam int STAT_BUSY    = 7;
   // reset values and the index of the last received bit
   localparam logic [7:0] BAUD_RESET = 8'h04;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [2:0] LAST_BIT   = 3'h7;
   // engine states
   typedef enum logic [3:0] {
      ST_IDLE     = 4'h0,
      ST_RX_LOW   = 4'h1,
      ST_RX_HIGH  = 4'h2,
      ST_ACK_LOW  = 4'h3,
      ST_ACK_HIGH = 4'h4,
      ST_STOP_SDA = 4'h5,
      ST_STOP_SCL = 4'h6,
      ST_STOP_REL = 4'h7
   } i2m_state_t;
   // sticky status flags kept together
   typedef struct packed {
      logic start_det;
      logic stop_det;
      logic bcl;
      logic pif;
      logic write_collision_flag;
      logic ov;
      logic buffer_full_flag;
   } i2m_flags_t;
endpackage

// ### rtl/i2m_baud.sv
// baud-rate reload counter: one period is the reload value counted down to zero
`timescale 1ns/100ps
`default_nettype none
module i2m_baud
   import i2m_pkg::*;
#(
   parameter int BAUD_W = 8
)(
   input  wire logic              sys_clk_in,
   input  wire logic              sys_rst_in,
   input  wire logic              ce_in,
   input  wire logic              load_in,
   input  wire logic              run_in,
   input  wire logic [BAUD_W-1:0] reload_in,
   output logic                   tick_out
);
   logic [BAUD_W-1:0] count;

   // refuse widths the reload field cannot serve, at elaboration
   if (BAUD_W < 2 || BAUD_W > 16)
   begin : g_bad_width
      $error("i2m_baud: BAUD_W out of range");
   end

   // rollover only while running; the tick must not look at load, which the
   // sequencer decodes from the tick itself and would close a logic loop
   assign tick_out = run_in && (count == '0);

   // reload on load or rollover, count down while running
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         count <= '0;
      end
      else if (ce_in)
      begin
         if (load_in || tick_out)
         begin
            count <= reload_in;
         end
         else if (run_in)
         begin
            count <= count - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ### rtl/i2m_rx_engine.sv
// i2c master receive, acknowledge and stop engine with apb registers
// Contract
// - receive enable is dropped unless the engine is idle when written
// - receiving: toggle scl per baud rollover, shift sda into shift register
// - after eighth fall: clear enable, load buffer, set flags, hold scl low
// - buffer full sets on load, clears when cpu reads buffer
// - byte completing while buffer full sets overflow
// - buffer write during receive sets write collision, buffer kept
// - ack sequence pulls scl low and drives ack data on sda
// - ack: one baud low, release scl, count baud after scl high
// - ack end clears enable, stops counter, goes idle, sets interrupt flag
// - buffer write during ack sets write collision, buffer kept
// - stop: sda low, count after sda low, release scl, then sda
// - sda high with scl high sets stop seen; baud later finish
// - buffer write during stop sets write collision, buffer kept
// - reset disables engine and abandons any transfer
// - start and stop seen bits clear on reset and disable
// - busy bus with interrupt enabled: stop on bus raises flag
// - sda sampled low while released for a not-acknowledge during ack high records bus collision
// - every reload takes the 8-bit baud reload field
// - collision sets flag, releases both lines, engine goes idle
`timescale 1ns/100ps
`default_nettype none
module i2m_rx_engine
   import i2m_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        ce_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             scl_out,
   output logic             scl_oe_out,
   output logic             sda_out,
   output logic             sda_oe_out
);
   i2m_state_t  state;
   i2m_state_t  next_state;
   i2m_flags_t  flags;
   logic        enable;
   logic        receive_enable_bit;
   logic        ack_sequence_enable;
   logic        ack_data_bit;
   logic        stopen;
   logic        stopie;
   logic [7:0]  baud_reload;
   logic [7:0]  data_buf;
   logic [7:0]  shift_reg;
   logic [2:0]  bit_cnt;
   logic        scl_meta;
   logic        scl_s;
   logic        sda_meta;
   logic        sda_s;
   logic        scl_d;
   logic        sda_d;
   logic        next_scl_low;
   logic        next_sda_low;
   logic        brg_run;
   logic        brg_tick;
   logic        brg_load;
   logic        done_xfer;
   logic        wr_ctrl;
   logic        wr_data;
   logic        wr_stat;
   logic        rd_data;
   logic        rx_done;
   logic        ack_done;
   logic        stop_done;
   logic        bcl_evt;
   logic        bus_stop;
   logic        bus_start;

   // address match used by every access decode
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction

   // transfer completes at the edge where the slave shows ready
   assign done_xfer = psel_in && penable_in && pready_out;
   assign wr_ctrl   = ce_in && done_xfer && pwrite_in && hit(paddr_in, OFF_CTRL);
   assign wr_data   = ce_in && done_xfer && pwrite_in && hit(paddr_in, OFF_DATA);
   assign wr_stat   = ce_in && done_xfer && pwrite_in && hit(paddr_in, OFF_STATUS);
   assign rd_data   = ce_in && done_xfer && !pwrite_in && hit(paddr_in, OFF_DATA);

   // two-flop synchronisers plus a delayed copy; the second stage and the delayed copy are read
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         scl_meta <= 1'b1;
         scl_s    <= 1'b1;
         sda_meta <= 1'b1;
         sda_s    <= 1'b1;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
      end
      else if (ce_in)
      begin
         scl_meta <= scl_in;
         scl_s    <= scl_meta;
         sda_meta <= sda_in;
         sda_s    <= sda_meta;
         scl_d    <= scl_s;
         sda_d    <= sda_s;
      end
   end

   // bus condition detection runs whether or not this master is active
   assign bus_stop  = ce_in && scl_s && scl_d && sda_s && !sda_d;
   assign bus_start = ce_in && scl_s && scl_d && !sda_s && sda_d;

   // lost arbitration: released sda seen low while scl high during ack
   // compares against the registered drive, so no loop through the sequencer
   assign bcl_evt = ce_in && enable && (state == ST_ACK_HIGH) && !sda_oe_out
                    && ack_data_bit && scl_s && !sda_s;

   // count only while the line that gates the phase allows it
   always_comb
   begin
      brg_run = 1'b0;
      case (state)
         ST_RX_LOW:   brg_run = 1'b1;
         ST_RX_HIGH:  brg_run = scl_s;        // stretched clock holds the count
         ST_ACK_LOW:  brg_run = 1'b1;
         ST_ACK_HIGH: brg_run = scl_s;
         ST_STOP_SDA: brg_run = !sda_s;
         ST_STOP_SCL: brg_run = 1'b1;
         ST_STOP_REL: brg_run = 1'b1;
         default:     brg_run = 1'b0;
      endcase
   end

   assign brg_load = ce_in && (next_state != state);

   i2m_baud #(
      .BAUD_W (8)
   ) u_baud (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .ce_in      (ce_in),
      .load_in    (brg_load),
      .run_in     (brg_run && ce_in),
      .reload_in  (baud_reload),
      .tick_out   (brg_tick)
   );

   // sequencer: next state and intended line drive
   always_comb
   begin
      next_state   = state;
      next_scl_low = scl_oe_out;
      next_sda_low = sda_oe_out;
      rx_done      = 1'b0;
      ack_done     = 1'b0;
      stop_done    = 1'b0;
      case (state)
         ST_IDLE:
         begin
            if (wr_ctrl && pwdata_in[CTRL_ENABLE] && pwdata_in[CTRL_RX_START])
            begin
               next_state   = ST_RX_LOW;
               next_scl_low = 1'b1;
               next_sda_low = 1'b0;
            end
            else if (wr_ctrl && pwdata_in[CTRL_ENABLE] && pwdata_in[CTRL_ACK_START])
            begin
               next_state   = ST_ACK_LOW;
               next_scl_low = 1'b1;
               next_sda_low = !pwdata_in[CTRL_ACK_DATA];
            end
            else if (wr_ctrl && pwdata_in[CTRL_ENABLE] && pwdata_in[CTRL_STOPEN])
            begin
               next_state   = ST_STOP_SDA;
               next_sda_low = 1'b1;
            end
         end
         ST_RX_LOW:
         begin
            if (brg_tick)
            begin
               next_state   = ST_RX_HIGH;
               next_scl_low = 1'b0;
            end
         end
         ST_RX_HIGH:
         begin
            if (brg_tick)
            begin
               next_scl_low = 1'b1;
               if (bit_cnt == LAST_BIT)
               begin
                  next_state = ST_IDLE;
                  rx_done    = 1'b1;
               end
               else
               begin
                  next_state = ST_RX_LOW;
               end
            end
         end
         ST_ACK_LOW:
         begin
            if (brg_tick)
            begin
               next_state   = ST_ACK_HIGH;
               next_scl_low = 1'b0;
            end
         end
         ST_ACK_HIGH:
         begin
            if (brg_tick)
            begin
               next_state   = ST_IDLE;
               next_scl_low = 1'b1;
               ack_done     = 1'b1;
            end
         end
         ST_STOP_SDA:
         begin
            if (brg_tick)
            begin
               next_state   = ST_STOP_SCL;
               next_scl_low = 1'b0;
            end
         end
         ST_STOP_SCL:
         begin
            if (brg_tick)
            begin
               next_state   = ST_STOP_REL;
               next_sda_low = 1'b0;
            end
         end
         ST_STOP_REL:
         begin
            if (brg_tick)
            begin
               next_state = ST_IDLE;
               stop_done  = 1'b1;
            end
         end
         default:
         begin
            next_state   = ST_IDLE;
            next_scl_low = 1'b0;
            next_sda_low = 1'b0;
         end
      endcase
      if (!enable || bcl_evt)
      begin
         next_state   = ST_IDLE;
         next_scl_low = 1'b0;
         next_sda_low = 1'b0;
         rx_done      = 1'b0;
         ack_done     = 1'b0;
         stop_done    = 1'b0;
      end
   end

   // state and open-drain drive; outputs only ever pull low
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         state      <= ST_IDLE;
         scl_oe_out <= 1'b0;
         sda_oe_out <= 1'b0;
         scl_out    <= 1'b0;
         sda_out    <= 1'b0;
      end
      else if (ce_in)
      begin
         state      <= next_state;
         scl_oe_out <= next_scl_low;
         sda_oe_out <= next_sda_low;
      end
   end

   // receive shifter samples sda at the end of each high phase
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         shift_reg <= DATA_RESET;
         bit_cnt   <= '0;
      end
      else if (ce_in)
      begin
         if (state == ST_IDLE)
         begin
            bit_cnt <= '0;
         end
         else if (state == ST_RX_HIGH && brg_tick)
         begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt   <= bit_cnt + 3'h1;
         end
      end
   end

   // control bits; command bits self-clear when their sequence ends
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         enable              <= 1'b0;
         receive_enable_bit  <= 1'b0;
         ack_sequence_enable <= 1'b0;
         ack_data_bit        <= 1'b0;
         stopen              <= 1'b0;
         stopie              <= 1'b0;
         baud_reload         <= BAUD_RESET;
      end
      else if (ce_in)
      begin
         if (wr_ctrl)
         begin
            enable       <= pwdata_in[CTRL_ENABLE];
            stopie       <= pwdata_in[CTRL_STOPIE];
            ack_data_bit <= pwdata_in[CTRL_ACK_DATA];
         end
         if (wr_ctrl && state == ST_IDLE && next_state != ST_IDLE)
         begin
            receive_enable_bit  <= (next_state == ST_RX_LOW);
            ack_sequence_enable <= (next_state == ST_ACK_LOW);
            stopen              <= (next_state == ST_STOP_SDA);
         end
         else if (next_state == ST_IDLE)
         begin
            receive_enable_bit  <= 1'b0;
            ack_sequence_enable <= 1'b0;
            stopen <= 1'b0;
         end
         if (done_xfer && pwrite_in && hit(paddr_in, OFF_BAUD))
         begin
            baud_reload <= pwdata_in[7:0];
         end
      end
   end

   // data buffer: receive load, cpu write only while idle
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         data_buf <= DATA_RESET;
      end
      else if (ce_in)
      begin
         if (rx_done)
         begin
            data_buf <= {shift_reg[6:0], sda_s};
         end
         else if (wr_data && state == ST_IDLE)
         begin
            data_buf <= pwdata_in[7:0];
         end
      end
   end

   // sticky flags; a hardware set beats a same-cycle clear, except start and stop seen, held clear while disabled
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         flags <= '0;
      end
      else if (ce_in)
      begin
         if (rd_data)
            flags.buffer_full_flag <= 1'b0;
         if (rx_done)
            flags.buffer_full_flag <= 1'b1;
         if (wr_stat && pwdata_in[STAT_OV])
            flags.ov <= 1'b0;
         if (rx_done && flags.buffer_full_flag && !rd_data)
            flags.ov <= 1'b1;
         if (wr_stat && pwdata_in[STAT_COLLIDE])
            flags.write_collision_flag <= 1'b0;
         if (wr_data && state != ST_IDLE)
            flags.write_collision_flag <= 1'b1;
         if (wr_stat && pwdata_in[STAT_PIF])
            flags.pif <= 1'b0;
         if (rx_done || ack_done || stop_done)
            flags.pif <= 1'b1;
         if (bus_stop && stopie && flags.start_det)
            flags.pif <= 1'b1;
         if (wr_stat && pwdata_in[STAT_BCL])
            flags.bcl <= 1'b0;
         if (bcl_evt)
            flags.bcl <= 1'b1;
         if (!enable)
         begin
            flags.stop_det  <= 1'b0;
            flags.start_det <= 1'b0;
         end
         else if (bus_stop)
         begin
            flags.stop_det  <= 1'b1;
            flags.start_det <= 1'b0;
         end
         else if (bus_start)
         begin
            flags.start_det <= 1'b1;
            flags.stop_det  <= 1'b0;
         end
      end
   end

   // apb slave: one wait state, registered answer
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= '0;
      end
      else if (ce_in)
      begin
         pready_out  <= psel_in && penable_in && !pready_out;
         pslverr_out <= psel_in && penable_in && !pready_out
                        && !(hit(paddr_in, OFF_CTRL) || hit(paddr_in, OFF_BAUD)
                        || hit(paddr_in, OFF_DATA) || hit(paddr_in, OFF_STATUS));
         prdata_out  <= '0;
         if (psel_in && penable_in && !pready_out && !pwrite_in)
         begin
            if (hit(paddr_in, OFF_CTRL))
               prdata_out[5:0] <= {stopie, stopen, ack_data_bit, ack_sequence_enable,
                                   receive_enable_bit, enable};
            else if (hit(paddr_in, OFF_BAUD))
               prdata_out[7:0] <= baud_reload;
            else if (hit(paddr_in, OFF_DATA))
               prdata_out[7:0] <= data_buf;
            else if (hit(paddr_in, OFF_STATUS))
               prdata_out[7:0] <= {state != ST_IDLE, flags};
         end
      end
   end

   // checks on the engine's own behaviour
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_rx_finish;
      rx_done ##1 (flags.buffer_full_flag && flags.pif && !receive_enable_bit && scl_oe_out);
   endsequence

   sequence s_ack_finish;
      ack_done ##1 (state == ST_IDLE && !ack_sequence_enable && flags.pif);
   endsequence

   // a busy engine may legally pass through the receive states, so watch the bit
   a_rx_ignore_busy: assert property (
      (wr_ctrl && state != ST_IDLE && pwdata_in[CTRL_RX_START]) |=> !$rose(receive_enable_bit))
      else $error("receive enable taken while busy");
   a_rx_done_flags: assert property (
      rx_done |-> s_rx_finish)
      else $error("receive end did not load flags");
   a_rx_overflow: assert property (
      (rx_done && flags.buffer_full_flag && !rd_data) |=> flags.ov)
      else $error("overflow not flagged");
   a_write_collision_flag_keep_buf: assert property (
      (wr_data && state != ST_IDLE && !rx_done)
      |=> flags.write_collision_flag && $stable(data_buf))
      else $error("busy buffer write not refused");
   a_ack_finish: assert property (
      ack_done |-> s_ack_finish)
      else $error("ack end incomplete");
   a_ack_scl_low: assert property (
      (state == ST_ACK_LOW) [*2] |-> scl_oe_out)
      else $error("scl not held low in ack");
   a_stop_finish: assert property (
      stop_done |=> !stopen && flags.pif && state == ST_IDLE)
      else $error("stop end incomplete");
   a_disable_clear: assert property (
      (ce_in && !enable) |=> !flags.stop_det && !flags.start_det)
      else $error("bus status not cleared");
   a_bcl_release: assert property (
      bcl_evt |=> flags.bcl && !scl_oe_out && !sda_oe_out && state == ST_IDLE)
      else $error("collision did not release bus");
endmodule
`default_nettype wire

// ### verif/i2m_slave_model.sv
// partner model: i2c slave that returns bytes and watches the acknowledge
`timescale 1ns/100ps
`default_nettype none
module i2m_slave_model (
   input  wire logic       sys_clk_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       load_in,
   input  wire logic [7:0] tx_in,
   input  wire logic       clash_in,
   output logic            sda_low_out,
   output logic            ack_seen_out
);
   logic       scl_q = 1'b1;
   logic       up    = 1'b0;
   logic       drv   = 1'b0;
   logic [3:0] cnt   = 4'h0;
   logic [7:0] sh    = 8'h00;
   // only pulls low; in the ack slot it may fight the master on command
   assign sda_low_out = (cnt == 4'h9) ? clash_in : drv;
   // bits change just after scl falls, so they stand still while scl is high
   always @(posedge sys_clk_in)
   begin
      scl_q <= scl_in;
      if (!scl_q && scl_in)
         up <= 1'b1;
      if (load_in)
      begin
         drv <= !tx_in[7];
         sh  <= {tx_in[6:0], 1'b0};
         cnt <= 4'h1;
         up  <= 1'b0; // the fall that opens the byte is not a bit end
      end
      else if (scl_q && !scl_in && up && cnt != 4'h0) // idle slave ignores stray clocks
      begin
         drv <= (cnt < 4'h8) ? !sh[7] : 1'b0;
         sh  <= {sh[6:0], 1'b0};
         cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
         up  <= 1'b0;
      end
      else if (!scl_q && scl_in && cnt == 4'h9)
         ack_seen_out <= sda_in;
   end
endmodule
`default_nettype wire

// ### verif/i2m_rx_engine_tb.sv
// self-checking bench: receive, acknowledge and stop over apb
`timescale 1ns/100ps
`default_nettype none
module i2m_rx_engine_tb
   import i2m_pkg::*;
();
   localparam logic [31:0] CE = 32'h21; // enable with stop interrupt on
   logic        sys_clk_in, sys_rst_in, psel_in, penable_in, pwrite_in, pready_out;
   logic        pslverr_out, scl_out, sda_out, scl_oe_out, sda_oe_out, sda_low_out;
   logic        ack_seen_out, load_in, clash_in, ext_scl, ext_sda, rerr;
   logic [7:0]  paddr_in, tx_in;
   logic [31:0] pwdata_in, prdata_out, rdat, st, seed;
   logic [7:0]  exp_q[$];
   int          mismatches, samples_checked, i;
   wire logic   ce_in = 1'b1;
   // open-drain wires: low while any party pulls, pull-up otherwise
   wire logic   scl_in = !scl_oe_out && !ext_scl;
   wire logic   sda_in = !sda_oe_out && !sda_low_out && !ext_sda;

   i2m_rx_engine i2m_rx_engine_inst (.sys_clk_in, .sys_rst_in, .ce_in, .psel_in,
      .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
      .pslverr_out, .scl_in, .sda_in, .scl_out, .scl_oe_out, .sda_out, .sda_oe_out);
   i2m_slave_model i2m_slave_model_inst (.sys_clk_in, .scl_in, .sda_in, .load_in,
      .tx_in, .clash_in, .sda_low_out, .ack_seen_out);

   // 50 MHz system clock
   initial
   begin
      sys_clk_in = 1'b0;
      forever #10 sys_clk_in = ~sys_clk_in;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string m);
      chk({31'h0, got}, {31'h0, exp}, m);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // one transfer; the request stands until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge sys_clk_in);
      penable_in <= 1'b1;
      for (n = 0; n < 20 && pready_out !== 1'b1; n++)
         @(posedge sys_clk_in);
      rdat = prdata_out;
      rerr = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge sys_clk_in);
      if (n == 20)
      begin
         chk(32'h0, 32'h1, "apb hang");
         end_of_test();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   // poll a flag, keep the status seen, then clear the four write-one-to-clear flags
   task automatic wait_bit(input int b);
      int n;
      for (n = 0; n < 300; n++)
      begin
         rd(OFF_STATUS);
         if (rdat[b] === 1'b1)
            break;
      end
      st = rdat;
      wr(OFF_STATUS, 32'h1E);
      if (n == 300)
      begin
         chk(32'h0, 32'h1, "flag hang");
         end_of_test();
      end
   endtask

   // arm the slave and start a receive; the buffer write must collide
   task automatic rx_byte();
      logic [31:0] r;
      r = xs();
      tx_in <= r[7:0];
      load_in <= 1'b1;
      exp_q.push_back(r[7:0]);
      @(posedge sys_clk_in);
      load_in <= 1'b0;
      wr(OFF_CTRL, CE | 32'h2);
      wr(OFF_DATA, 32'hA5);
   endtask

   // acknowledge; receive start and buffer write during it are refused
   task automatic ack(input logic d);
      wr(OFF_CTRL, CE | 32'h4 | {28'h0, d, 3'h0});
      wr(OFF_CTRL, CE | 32'h6 | {28'h0, d, 3'h0});
      wr(OFF_DATA, 32'h5A);
      wait_bit(STAT_PIF);
      chk_bit(st[STAT_COLLIDE], 1'b1, "ack collide");
      chk_bit(ack_seen_out, d, "ack bit");
      rd(OFF_CTRL);
      chk(rdat & 32'h6, 32'h0, "ack ctrl");
   endtask

   // main sequence
   initial
   begin
      seed = 32'd27;
      {sys_rst_in, psel_in, penable_in, pwrite_in, load_in, clash_in, ext_scl, ext_sda} = 8'h80;
      paddr_in = 8'h00;
      pwdata_in = 32'h0;
      tx_in = 8'h00;
      mismatches = 0;
      samples_checked = 0;
      repeat (6) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      rd(OFF_CTRL);
      chk(rdat, 32'h0, "ctrl rst");
      rd(OFF_BAUD);
      chk(rdat, {24'h0, BAUD_RESET}, "baud rst");
      rd(OFF_STATUS);
      chk(rdat, 32'h0, "stat rst");
      rd(8'h10);
      chk({rdat[30:0], rerr}, 32'h1, "unmapped");
      st = xs();
      wr(OFF_BAUD, {30'h0, st[1:0]} + 32'h1);
      wr(OFF_CTRL, CE);
      st = xs();
      wr(OFF_DATA, {24'h0, st[7:1], 1'b1});
      rd(OFF_DATA);
      chk(rdat, {24'h0, st[7:1], 1'b1}, "addr load");
      for (i = 0; i < 2; i++)
      begin
         rx_byte();
         wait_bit(STAT_PIF);
         chk({29'h0, st[2:0]}, 32'h5, "rx flags");
         chk_bit(scl_oe_out, 1'b1, "scl held");
         rd(OFF_CTRL);
         chk(rdat & 32'h2, 32'h0, "receive_enable_bit");
         rd(OFF_DATA);
         chk(rdat, {24'h0, exp_q.pop_front()}, "rx byte");
         rd(OFF_STATUS);
         chk_bit(rdat[STAT_FULL], 1'b0, "full");
         ack(i[0]);
      end
      // second byte lands while the first is unread
      rx_byte();
      wait_bit(STAT_PIF);
      rx_byte();
      wait_bit(STAT_PIF);
      chk_bit(st[STAT_OV], 1'b1, "overflow");
      rd(OFF_DATA);
      exp_q.delete();
      ack(1'b1);
      wr(OFF_CTRL, CE | 32'h10);
      wr(OFF_DATA, 32'hC3);
      wait_bit(STAT_PIF);
      chk(st & 32'h24, 32'h24, "stop flags");
      chk_bit(scl_in && sda_in && !scl_oe_out && !sda_oe_out, 1'b1, "freed");
      // another master claims the freed bus, then stops
      ext_sda <= 1'b1;
      repeat (10) @(posedge sys_clk_in);
      ext_scl <= 1'b1;
      repeat (10) @(posedge sys_clk_in);
      ext_scl <= 1'b0;
      repeat (10) @(posedge sys_clk_in);
      ext_sda <= 1'b0;
      wait_bit(STAT_PIF);
      chk(st & 32'h60, 32'h20, "bus stop");
      wr(OFF_CTRL, 32'h0);
      rd(OFF_STATUS);
      chk(rdat & 32'h60, 32'h0, "seen clr");
      wr(OFF_CTRL, CE);
      // slave holds sda low against a not-acknowledge
      clash_in <= 1'b1;
      rx_byte();
      wait_bit(STAT_PIF);
      rd(OFF_DATA);
      chk(rdat, {24'h0, exp_q.pop_front()}, "rx byte");
      wr(OFF_CTRL, CE | 32'hC);
      wait_bit(STAT_BCL);
      chk_bit(scl_oe_out || sda_oe_out, 1'b0, "bcl free");
      rd(OFF_CTRL);
      chk(rdat & 32'h4, 32'h0, "bcl idle");
      clash_in <= 1'b0;
      // reset in mid-byte
      rx_byte();
      repeat (10) @(posedge sys_clk_in);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      chk_bit(scl_oe_out || sda_oe_out, 1'b0, "rst free");
      chk_bit(scl_out || sda_out, 1'b0, "od value");
      rd(OFF_CTRL);
      chk(rdat, 32'h0, "rst ctrl");
      rd(OFF_STATUS);
      chk(rdat & 32'h7F, 32'h0, "rst stat");
      end_of_test();
   end
endmodule
`default_nettype wire
